// ### common/sfa_pkg.sv
package sfa_pkg;
  // Array geometry: 27 address bits cover the 1Gb array
  localparam int ARR_AW = 27;
  localparam int SEG_LSB = 24;
  localparam int SEG_W = 3;
  localparam int SEC_LSB = 12;
  localparam int B32_LSB = 16 - 1;
  localparam int B64_LSB = 16;
  localparam int SEC_W = ARR_AW - SEC_LSB;
  localparam int B32_W = ARR_AW - B32_LSB;
  localparam int B64_W = ARR_AW - B64_LSB;
  localparam logic [7:0] UAB_RST = 8'h00;
  localparam logic [7:0] UAB_MASK = 8'h07;
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_KEEP_LSB = 2;
  // Instruction codes
  localparam logic [7:0] CMD_READ3 = 8'h03;
  localparam logic [7:0] CMD_READ4 = 8'h13;
  localparam logic [7:0] CMD_PW3 = 8'h02;
  localparam logic [7:0] CMD_PW4 = 8'h12;
  localparam logic [7:0] CMD_SMALL3 = 8'h20;
  localparam logic [7:0] CMD_SMALL4 = 8'h21;
  localparam logic [7:0] CMD_MID3 = 8'h52;
  localparam logic [7:0] CMD_MID4 = 8'h5C;
  localparam logic [7:0] CMD_LARGE3 = 8'hD8;
  localparam logic [7:0] CMD_LARGE4 = 8'hDC;
  localparam logic [7:0] CMD_FULL = 8'h60;
  localparam logic [7:0] CMD_WR_EN = 8'h06;
  localparam logic [7:0] CMD_WR_DIS = 8'h04;
  localparam logic [7:0] CMD_STAT_FETCH = 8'h05;
  localparam logic [7:0] CMD_STAT_STORE = 8'h01;
  localparam logic [7:0] CMD_WIDE_ON = 8'hB7;
  localparam logic [7:0] CMD_WIDE_OFF = 8'hE9;
  localparam logic [7:0] CMD_UAB_WR = 8'hC5;
  localparam logic [7:0] CMD_UAB_RD = 8'hC8;
  // Link timing
  localparam int CLK_NS = 40;
  localparam int SCK_PERIOD_NS = 320;
  localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * CLK_NS);
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PROG = 3'b001,
    OP_PROG_DROP = 3'b010,
    OP_SMALL_WIPE = 3'b011,
    OP_MID_WIPE = 3'b100,
    OP_LARGE_WIPE = 3'b101,
    OP_FULL_WIPE = 3'b110,
    OP_STATUS_STORE = 3'b111
  } sfa_op_e;
  typedef enum logic [2:0] {
    D_CMD = 3'b000,
    D_ADDR = 3'b001,
    D_DIN = 3'b010,
    D_DOUT = 3'b011,
    D_IGNORE = 3'b100
  } sfa_dst_e;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW = 3'b001,
    H_HIGH = 3'b010,
    H_END = 3'b011,
    H_REST = 3'b100
  } sfa_hst_e;
endpackage

// ### common/sfa_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfa_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic so_level;
  // Released output line is pulled high
  assign so_level = miso_oe ? miso : 1'b1;
  modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, input so_level);
endinterface
`default_nettype wire

// ### rtl/sfa_dev_end.sv
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Array is 2048 64K-byte blocks
// - Host should poll status before commands
// - Unknown opcode: release output, ignore until reselect
// - Known opcode: active until chip select rises; a read while busy drops it after the address
// - Sample on rising, launch on falling, modes 0/3
// - Reads stream out; deselect anytime is fine
// - Write-type needs deselect on byte boundary
// - Array access ignored while busy
// - Wide-on sets flag; 32-bit addresses then
// - Wide-off clears flag; back to 3 bytes
// - Dedicated 4-byte opcodes always take 32 bits
// - Wide mode ignores the upper address byte
// - 8-bit upper byte supplies address bits 31..24
// - Top five bits read zero; resets zero
// - Low three bits pick 128Mb segment
// - Stream read crosses segments, byte unchanged
// - Random reads start inside selected segment
// - Full wipe ignores segment selection
// - Erase and program stay inside segment
module sfa_dev_end (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic clk_en, // Freezes all state when low
  sfa_link_if.dev link, // Serial link, device end
  input wire logic array_busy, // Array operation in progress
  input wire logic [7:0] rd_data, // Array byte, cycle after rd_req
  output logic rd_req, // Array byte fetch, pulse
  output logic [sfa_pkg::ARR_AW-1:0] rd_addr, // Fetch address
  output logic wr_valid, // Program data byte, pulse
  output logic [sfa_pkg::ARR_AW-1:0] wr_addr, // Program byte address
  output logic [7:0] wr_data, // Program byte
  output logic op_valid, // Operation issue, pulse
  output sfa_pkg::sfa_op_e op_kind, // Issued operation
  output logic [sfa_pkg::ARR_AW-1:0] op_addr, // Operation start address
  output logic [sfa_pkg::SEC_W-1:0] op_sector, // Sector index
  output logic [sfa_pkg::B32_W-1:0] op_blk32, // 32K block index
  output logic [sfa_pkg::B64_W-1:0] op_blk64, // 64K block index
  output logic wide_addr_flag, // 4-byte address mode
  output logic [7:0] upper_addr_byte, // Upper address byte
  output logic [7:0] status_out, // Status register image
  output logic active // Valid instruction in progress
);
  import sfa_pkg::*;

  logic [2:0] s0;
  logic [2:0] s1;
  logic [2:0] s1_d;
  logic [2:0] bit_cnt;
  logic [2:0] ocnt;
  logic [1:0] addr_cnt;
  logic [7:0] in_sh;
  logic [7:0] opcode;
  logic [7:0] pend;
  logic [7:0] out_sh;
  logic [7:0] pre;
  logic [31:0] addr;
  logic [ARR_AW-1:0] eff_addr;
  logic [ARR_AW-1:0] start_addr;
  logic [5:0] stat_keep;
  logic addr_wide;
  logic got_data;
  logic wel;
  logic out_ok;
  logic first;
  logic rd_wait;
  sfa_dst_e state;

  wire cs_lo = ~s1[2];
  wire sck = s1[1];
  wire din = s1[0];
  wire sck_rise = sck & ~s1_d[1];
  wire sck_fall = ~sck & s1_d[1];
  wire cs_rise = s1[2] & ~s1_d[2];
  wire [7:0] next_in = {in_sh[6:0], din};
  wire byte_end = cs_lo & sck_rise & (bit_cnt == 3'd7);
  wire [7:0] code = (state == D_CMD) ? next_in : opcode;

  wire c_rd3 = code == CMD_READ3;
  wire c_rd4 = code == CMD_READ4;
  wire c_pw3 = code == CMD_PW3;
  wire c_pw4 = code == CMD_PW4;
  wire c_sm3 = code == CMD_SMALL3;
  wire c_sm4 = code == CMD_SMALL4;
  wire c_md3 = code == CMD_MID3;
  wire c_md4 = code == CMD_MID4;
  wire c_lg3 = code == CMD_LARGE3;
  wire c_lg4 = code == CMD_LARGE4;
  wire c_full = code == CMD_FULL;
  wire c_wr_en = code == CMD_WR_EN;
  wire c_wr_dis = code == CMD_WR_DIS;
  wire c_rd_stat = code == CMD_STAT_FETCH;
  wire c_stat_st = code == CMD_STAT_STORE;
  wire c_wide_on = code == CMD_WIDE_ON;
  wire c_wide_off = code == CMD_WIDE_OFF;
  wire c_uab_wr = code == CMD_UAB_WR;
  wire c_uab_rd = code == CMD_UAB_RD;
  wire c_rd = c_rd3 | c_rd4;
  wire c_pw = c_pw3 | c_pw4;
  wire c_small = c_sm3 | c_sm4;
  wire c_mid = c_md3 | c_md4;
  wire c_large = c_lg3 | c_lg4;
  wire c_erase = c_small | c_mid | c_large;
  wire c_4b = c_rd4 | c_pw4 | c_sm4 | c_md4 | c_lg4;
  wire c_addr = c_rd | c_pw | c_erase;
  wire c_known = c_addr | c_full | c_wr_en | c_wr_dis | c_rd_stat | c_stat_st
               | c_wide_on | c_wide_off | c_uab_wr | c_uab_rd;

  wire addr_last = addr_cnt == (addr_wide ? 2'd3 : 2'd2);
  wire [31:0] addr_full = {addr[23:0], next_in};
  // wide address bypasses the upper byte
  // segment bits placed over 24 address bits
  wire [ARR_AW-1:0] eff_new = addr_wide ? addr_full[ARR_AW-1:0]
                            : {upper_addr_byte[SEG_W-1:0], addr_full[SEG_LSB-1:0]};
  wire addr_end = byte_end & (state == D_ADDR) & addr_last;
  wire start_rd = addr_end & c_rd & ~array_busy;
  wire start_reg = byte_end & (state == D_CMD) & (c_rd_stat | c_uab_rd);
  wire [7:0] status_val = {stat_keep, wel, array_busy};
  // unused upper bits read as zero
  wire [7:0] uab_val = upper_addr_byte & UAB_MASK;
  wire [7:0] reload = c_rd ? pre : (c_rd_stat ? status_val : uab_val);
  wire may_write = wel & ~array_busy;
  wire pw_ok = byte_end & (state == D_DIN) & c_pw & may_write;
  // execute only on a byte boundary
  wire frame_ok = cs_rise & (state == D_DIN) & (bit_cnt == 3'd0);
  wire exec = frame_ok & may_write & (c_erase | c_full | ((c_pw | c_stat_st) & got_data));
  wire drop = cs_rise & (state == D_DIN) & c_pw & got_data & wel & (bit_cnt != 3'd0);
  wire sfa_dst_e st_cmd = ~c_known ? D_IGNORE
                        : c_addr ? D_ADDR
                        : (c_rd_stat | c_uab_rd) ? D_DOUT : D_DIN;
  wire sfa_dst_e st_addr = ~c_rd ? D_DIN : (array_busy ? D_IGNORE : D_DOUT);
  wire sfa_op_e exec_kind = c_pw ? OP_PROG
                          : c_small ? OP_SMALL_WIPE
                          : c_mid ? OP_MID_WIPE
                          : c_large ? OP_LARGE_WIPE
                          : c_full ? OP_FULL_WIPE : OP_STATUS_STORE;
  wire [ARR_AW-1:0] op_a = c_full ? '0 : start_addr;

  // Pins come from the host's domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s0 <= 3'b100;
      s1 <= 3'b100;
      s1_d <= 3'b100;
    end else if (clk_en) begin
      s0 <= {link.cs_n, link.sclk, link.mosi};
      s1 <= s0;
      s1_d <= s1;
    end
  end

  // input bits taken on rising edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= D_CMD;
      bit_cnt <= 3'd0;
      addr_cnt <= 2'd0;
      in_sh <= 8'h00;
      opcode <= 8'h00;
      addr <= 32'h0;
      addr_wide <= 1'b0;
      got_data <= 1'b0;
      pend <= 8'h00;
      eff_addr <= '0;
      start_addr <= '0;
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_data <= 8'h00;
      active <= 1'b0;
    end else if (clk_en) begin
      wr_valid <= 1'b0;
      active <= cs_lo & (state != D_CMD) & (state != D_IGNORE);
      if (!cs_lo) begin
        state <= D_CMD;
        bit_cnt <= 3'd0;
        addr_cnt <= 2'd0;
        got_data <= 1'b0;
      end else if (sck_rise) begin
        in_sh <= next_in;
        bit_cnt <= bit_cnt + 3'd1;
        if (byte_end) begin
          unique case (state)
            D_CMD: begin
              opcode <= next_in;
              // flag stretches addresses to 32 bits
              addr_wide <= c_4b | wide_addr_flag;
              state <= st_cmd;
            end
            D_ADDR: begin
              addr <= addr_full;
              addr_cnt <= addr_cnt + 2'd1;
              if (addr_last) begin
                eff_addr <= eff_new;
                start_addr <= eff_new;
                state <= st_addr;
              end
            end
            D_DIN: begin
              got_data <= 1'b1;
              if (!got_data) begin
                pend <= next_in;
              end
              if (pw_ok) begin
                wr_valid <= 1'b1;
                wr_data <= next_in;
                wr_addr <= eff_addr;
                eff_addr <= {eff_addr[ARR_AW-1:SEG_LSB], eff_addr[SEG_LSB-1:0] + 1'b1};
              end
            end
            D_DOUT: begin
            end
            D_IGNORE: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wel <= 1'b0;
      wide_addr_flag <= 1'b0;
      upper_addr_byte <= UAB_RST;
      stat_keep <= 6'h00;
      status_out <= 8'h00;
      op_valid <= 1'b0;
      op_kind <= OP_NONE;
      op_addr <= '0;
      op_sector <= '0;
      op_blk32 <= '0;
      op_blk64 <= '0;
    end else if (clk_en) begin
      op_valid <= 1'b0;
      status_out <= status_val;
      if (frame_ok & c_wr_en) begin
        wel <= 1'b1;
      end else if ((frame_ok & c_wr_dis) | exec) begin
        wel <= 1'b0;
      end
      if (frame_ok & c_wide_on) begin
        wide_addr_flag <= 1'b1;
      end else if (frame_ok & c_wide_off) begin
        wide_addr_flag <= 1'b0;
      end
      // store upper byte, top bits zero
      if (frame_ok & c_uab_wr & got_data) begin
        upper_addr_byte <= pend & UAB_MASK;
      end
      if (exec & c_stat_st) begin
        stat_keep <= pend[7:ST_KEEP_LSB];
      end
      if (exec | drop) begin
        op_valid <= 1'b1;
        op_kind <= drop ? OP_PROG_DROP : exec_kind;
        op_addr <= op_a;
        op_sector <= op_a[ARR_AW-1:SEC_LSB];
        op_blk32 <= op_a[ARR_AW-1:B32_LSB];
        op_blk64 <= op_a[ARR_AW-1:B64_LSB];
      end
    end
  end

  // Output byte is fetched ahead so a launch never waits on the array
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_req <= 1'b0;
      rd_addr <= '0;
      rd_wait <= 1'b0;
      first <= 1'b0;
      out_ok <= 1'b0;
      out_sh <= 8'h00;
      pre <= 8'h00;
      ocnt <= 3'd0;
      link.miso <= 1'b0;
      link.miso_oe <= 1'b0;
    end else if (clk_en) begin
      rd_req <= 1'b0;
      rd_wait <= rd_req;
      if (!cs_lo) begin
        link.miso_oe <= 1'b0;
        out_ok <= 1'b0;
        first <= 1'b0;
        ocnt <= 3'd0;
      end else begin
        if (start_rd) begin
          rd_req <= 1'b1;
          rd_addr <= eff_new;
          first <= 1'b1;
        end
        if (start_reg) begin
          out_sh <= c_rd_stat ? status_val : uab_val;
          out_ok <= 1'b1;
        end
        if (rd_wait) begin
          if (first) begin
            out_sh <= rd_data;
            out_ok <= 1'b1;
            first <= 1'b0;
            rd_req <= 1'b1;
            rd_addr <= rd_addr + 1'b1;
          end else begin
            pre <= rd_data;
          end
        end
        if (sck_fall & (state == D_DOUT) & out_ok) begin
          link.miso <= out_sh[7];
          link.miso_oe <= 1'b1;
          ocnt <= ocnt + 3'd1;
          if (ocnt == 3'd7) begin
            out_sh <= reload;
            if (c_rd) begin
              rd_req <= 1'b1;
              rd_addr <= rd_addr + 1'b1;
            end
          end else begin
            out_sh <= {out_sh[6:0], 1'b0};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/sfa_host_end.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_host_end #(
  parameter int HALF = sfa_pkg::SCK_HALF_CYC, // Serial clock phase, clk cycles
  parameter bit CPOL = 1'b0 // Idle level: 0 mode 0, 1 mode 3
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic clk_en, // Freezes all state when low
  sfa_link_if.host link, // Serial link, host end
  input wire logic start, // Begin one frame, pulse
  input wire logic [7:0] opcode, // Instruction byte
  input wire logic [31:0] addr, // Address, low bytes used
  input wire logic [2:0] addr_bytes, // Address bytes: 0, 3 or 4
  input wire logic [8:0] tx_len, // Data bytes sent
  input wire logic [8:0] rx_len, // Data bytes received
  input wire logic [7:0] tx_data, // Next byte to send, held
  output logic tx_take, // tx_data consumed, pulse
  output logic [7:0] rx_data, // Received byte
  output logic rx_valid, // rx_data new, pulse
  output logic busy // Frame in progress
);
  import sfa_pkg::*;

  sfa_hst_e state;
  logic [7:0] cnt;
  logic [7:0] sh;
  logic [7:0] rx_sh;
  logic [2:0] bit_i;
  logic [2:0] ab;
  logic [9:0] idx;
  logic [9:0] total;
  logic [9:0] tx_end;
  logic [31:0] a_reg;
  logic m0;
  logic m1;

  wire [9:0] nidx = idx + 10'd1;
  wire [2:0] lane = ab - 3'd1 - idx[2:0];
  wire [31:0] a_shift = a_reg >> {lane[1:0], 3'b000};
  wire in_addr = nidx <= {7'd0, ab};
  wire in_tx = nidx < tx_end;
  wire [7:0] nb = in_addr ? a_shift[7:0] : (in_tx ? tx_data : 8'h00);
  wire last_byte = nidx == total;
  wire phase_end = cnt == 8'(HALF - 1);
  wire rx_byte = idx >= tx_end;
  wire [7:0] rx_next = {rx_sh[6:0], m1};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m0 <= 1'b1;
      m1 <= 1'b1;
    end else if (clk_en) begin
      m0 <= link.so_level;
      m1 <= m0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= H_IDLE;
      cnt <= 8'd0;
      sh <= 8'h00;
      rx_sh <= 8'h00;
      bit_i <= 3'd0;
      ab <= 3'd0;
      idx <= 10'd0;
      total <= 10'd0;
      tx_end <= 10'd0;
      a_reg <= 32'h0;
      tx_take <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      busy <= 1'b0;
      link.cs_n <= 1'b1;
      link.sclk <= CPOL;
      link.mosi <= 1'b0;
    end else if (clk_en) begin
      tx_take <= 1'b0;
      rx_valid <= 1'b0;
      cnt <= (phase_end | (state == H_IDLE)) ? 8'd0 : cnt + 8'd1;
      unique case (state)
        H_IDLE: begin
          // status polling is left to the caller
          if (start) begin
            a_reg <= addr;
            ab <= addr_bytes;
            total <= 10'd1 + {7'd0, addr_bytes} + {1'b0, tx_len} + {1'b0, rx_len};
            tx_end <= 10'd1 + {7'd0, addr_bytes} + {1'b0, tx_len};
            idx <= 10'd0;
            bit_i <= 3'd0;
            sh <= {opcode[6:0], 1'b0};
            link.mosi <= opcode[7];
            link.cs_n <= 1'b0;
            link.sclk <= 1'b0;
            busy <= 1'b1;
            state <= H_LOW;
          end
        end
        H_LOW: begin
          if (phase_end) begin
            link.sclk <= 1'b1;
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          // data changes only with the falling edge
          if (phase_end) begin
            rx_sh <= rx_next;
            bit_i <= bit_i + 3'd1;
            link.sclk <= 1'b0;
            state <= H_LOW;
            if (bit_i == 3'd7) begin
              // read bytes delivered as they complete
              if (rx_byte) begin
                rx_valid <= 1'b1;
                rx_data <= rx_next;
              end
              // frames always end on a whole byte
              if (last_byte) begin
                link.sclk <= CPOL;
                state <= H_END;
              end else begin
                idx <= nidx;
                sh <= {nb[6:0], 1'b0};
                link.mosi <= nb[7];
                tx_take <= in_tx & ~in_addr;
              end
            end else begin
              link.mosi <= sh[7];
              sh <= {sh[6:0], 1'b0};
            end
          end
        end
        H_END: begin
          if (phase_end) begin
            link.cs_n <= 1'b1;
            state <= H_REST;
          end
        end
        H_REST: begin
          if (phase_end) begin
            busy <= 1'b0;
            state <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/sfa_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sfa_link_sva (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic cs_n, // Chip select, low active
  input wire logic sclk, // Serial clock
  input wire logic mosi, // Host data line
  input wire logic miso, // Device data line
  input wire logic miso_oe // Device drive enable
);
  // Bench runs mode 0 with a four-cycle phase
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  oe_release_a: assert property (cs_n [*5] |-> !miso_oe)
    else $error("output driven while deselected");
  oe_start_a: assert property ($rose(miso_oe) |-> !cs_n)
    else $error("output enabled outside a frame");
  miso_hold_a: assert property (miso_oe && sclk && $past(sclk) |-> $stable(miso))
    else $error("output changed in high phase");
  mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("input line changed in high phase");
  clk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("serial clock not idle low");
  cs_edge_a: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
    else $error("select moved inside a bit");
  high_phase_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("high phase length wrong");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
    else $error("deselect gap too short");
endmodule
`default_nettype wire

// ### tb/test_serial_flash_cmd_addr_frontend.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_cmd_addr_frontend;
  import sfa_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic array_busy = 1'b0;
  logic act_seen = 1'b0;
  logic host_cut = 1'b0;
  int op_cnt = 0;
  logic [7:0] opcode = 8'h00;
  logic [31:0] addr = 32'h00000000;
  logic [2:0] addr_bytes = 3'h0;
  logic [8:0] tx_len = 9'h000;
  logic [8:0] rx_len = 9'h000;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rd_data = 8'h00;
  logic tx_take, rx_valid, busy, rd_req, wr_valid, op_valid, wide_addr_flag, active;
  logic [7:0] rx_data, wr_data, upper_addr_byte, status_out;
  logic [ARR_AW-1:0] rd_addr, wr_addr, op_addr, wr_last;
  logic [SEC_W-1:0] op_sector;
  logic [B32_W-1:0] op_blk32;
  logic [B64_W-1:0] op_blk64;
  sfa_op_e op_kind;
  logic [7:0] rxq[$];
  int err_total = 0;
  int num_checks = 0;
  sfa_link_if link ();
  always #20 clk = ~clk;
  sfa_dev_end i_sfa_dev_end (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .link(link.dev),
    .array_busy(array_busy), .rd_data(rd_data), .rd_req(rd_req), .rd_addr(rd_addr),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .op_valid(op_valid),
    .op_kind(op_kind), .op_addr(op_addr), .op_sector(op_sector), .op_blk32(op_blk32),
    .op_blk64(op_blk64), .wide_addr_flag(wide_addr_flag), .upper_addr_byte(upper_addr_byte),
    .status_out(status_out), .active(active));
  // Host-only reset cuts a frame in mid-byte
  sfa_host_end i_sfa_host_end (.clk(clk), .sys_rst(sys_rst | host_cut), .clk_en(1'b1),
    .link(link.host), .start(start), .opcode(opcode), .addr(addr), .addr_bytes(addr_bytes),
    .tx_len(tx_len), .rx_len(rx_len), .tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data),
    .rx_valid(rx_valid), .busy(busy));
  sfa_link_sva i_sfa_link_sva (.clk(clk), .sys_rst(sys_rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
  // Array content tags each byte with its segment
  function automatic logic [7:0] mem_byte(input logic [ARR_AW-1:0] a);
    return {a[26:24], a[4:0]};
  endfunction
  always @(posedge clk) begin
    rd_data <= mem_byte(rd_addr);
    if (rx_valid) rxq.push_back(rx_data);
    if (wr_valid) wr_last <= wr_addr;
    if (tx_take) tx_data <= tx_data + 8'h01;
    if (active) act_seen <= 1'b1;
    if (op_valid) op_cnt <= op_cnt + 1;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input logic [2:0] nab,
      input logic [8:0] ntx, input logic [8:0] nrx);
    int n;
    n = 0;
    rxq.delete();
    @(posedge clk);
    act_seen <= 1'b0;
    opcode <= op;
    addr <= a;
    addr_bytes <= nab;
    tx_len <= ntx;
    rx_len <= nrx;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) chk("frame end", 1, 0);
    // Room for the device to issue its operation
    repeat (8) @(negedge clk);
    chk("rx count", nrx, rxq.size());
  endtask
  // Host reset lands in the low phase of bit 3 of the sixth byte
  task automatic cut_frame(input logic [7:0] op);
    fork
      frame(op, 32'h00123456, 3, 2, 0);
      begin
        repeat (347) @(posedge clk);
        host_cut <= 1'b1;
        @(posedge clk);
        host_cut <= 1'b0;
      end
    join
  endtask
  task automatic t_reset();
    chk("upper byte", 8'h00, upper_addr_byte);
    chk("wide flag", 1'b0, wide_addr_flag);
    chk("op kind", OP_NONE, op_kind);
    $display("test reset done");
  endtask
  task automatic t_upper();
    tx_data <= 8'hFD;
    frame(CMD_UAB_WR, 0, 0, 1, 0);
    chk("upper byte", 8'h05, upper_addr_byte);
    frame(CMD_UAB_RD, 0, 0, 0, 1);
    chk("upper read", 8'h05, rxq[0]);
    $display("test upper byte done");
  endtask
  task automatic t_read();
    frame(CMD_READ3, 32'h00FFFFFE, 3, 0, 3);
    for (int i = 0; i < 3; i++) begin
      chk("stream byte", mem_byte(27'h5FFFFFE + 27'(i)), rxq[i]);
    end
    chk("upper kept", 8'h05, upper_addr_byte);
    chk("active seen", 1'b1, act_seen);
    frame(CMD_READ3, 32'h00000010, 3, 0, 1);
    chk("random read", mem_byte(27'h5000010), rxq[0]);
    $display("test read done");
  endtask
  task automatic t_write();
    logic [7:0] ops [3] = '{CMD_SMALL3, CMD_MID3, CMD_LARGE3};
    sfa_op_e kinds [3] = '{OP_SMALL_WIPE, OP_MID_WIPE, OP_LARGE_WIPE};
    logic [ARR_AW-1:0] ea = 27'h5123456;
    frame(CMD_WR_EN, 0, 0, 0, 0);
    frame(CMD_STAT_FETCH, 0, 0, 0, 1);
    chk("ready poll", 8'h02, rxq[0]);
    chk("status out", 8'h02, status_out);
    frame(CMD_PW3, 32'h00FFFFFF, 3, 2, 0);
    chk("prog kind", OP_PROG, op_kind);
    chk("prog wrap", 27'h5000000, wr_last);
    for (int i = 0; i < 3; i++) begin
      frame(CMD_WR_EN, 0, 0, 0, 0);
      frame(ops[i], 32'h00123456, 3, 0, 0);
      chk("wipe kind", kinds[i], op_kind);
      chk("wipe addr", ea, op_addr);
      chk("sector", ea[26:12], op_sector);
      chk("blk32", ea[26:15], op_blk32);
      chk("blk64", ea[26:16], op_blk64);
    end
    frame(CMD_WR_EN, 0, 0, 0, 0);
    frame(CMD_FULL, 0, 0, 0, 0);
    chk("full kind", OP_FULL_WIPE, op_kind);
    chk("full addr", 27'h0, op_addr);
    @(posedge clk);
    tx_data <= 8'hA8;
    frame(CMD_WR_EN, 0, 0, 0, 0);
    frame(CMD_STAT_STORE, 0, 0, 1, 0);
    chk("store kind", OP_STATUS_STORE, op_kind);
    frame(CMD_WR_EN, 0, 0, 0, 0);
    frame(CMD_WR_DIS, 0, 0, 0, 0);
    frame(CMD_STAT_FETCH, 0, 0, 0, 1);
    chk("status kept", 8'hA8, rxq[0]);
    $display("test write done");
  endtask
  task automatic t_wide();
    frame(CMD_WIDE_ON, 0, 0, 0, 0);
    chk("wide flag", 1'b1, wide_addr_flag);
    frame(CMD_READ3, 32'h07ABCDEF, 4, 0, 1);
    chk("wide read", mem_byte(27'h7ABCDEF), rxq[0]);
    frame(CMD_WIDE_OFF, 0, 0, 0, 0);
    chk("wide flag", 1'b0, wide_addr_flag);
    frame(CMD_READ4, 32'h02000010, 4, 0, 1);
    chk("dedicated read", mem_byte(27'h2000010), rxq[0]);
    $display("test wide done");
  endtask
  task automatic t_cut();
    int n;
    frame(CMD_WR_EN, 0, 0, 0, 0);
    cut_frame(CMD_PW3);
    chk("cut prog", OP_PROG_DROP, op_kind);
    n = op_cnt;
    cut_frame(CMD_SMALL3);
    chk("cut wipe", n, op_cnt);
    $display("test cut done");
  endtask
  task automatic t_refuse();
    int n;
    frame(8'hFF, 0, 0, 0, 1);
    chk("unknown out", 8'hFF, rxq[0]);
    chk("unknown active", 1'b0, act_seen);
    @(posedge clk);
    array_busy <= 1'b1;
    frame(CMD_READ3, 32'h00000010, 3, 0, 1);
    chk("busy read", 8'hFF, rxq[0]);
    frame(CMD_STAT_FETCH, 0, 0, 0, 1);
    chk("status busy", 1'b1, rxq[0][ST_WIP]);
    chk("status out busy", 1'b1, status_out[ST_WIP]);
    frame(CMD_WR_EN, 0, 0, 0, 0);
    n = op_cnt;
    frame(CMD_SMALL3, 32'h00123456, 3, 0, 0);
    chk("busy wipe", n, op_cnt);
    @(posedge clk);
    array_busy <= 1'b0;
    $display("test refuse done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_upper();
    t_read();
    t_write();
    t_wide();
    t_cut();
    t_refuse();
    print_verdict();
  end
endmodule
`default_nettype wire
